/* src/tmon_pkg.sv */
// Shared constants and types for the two-channel temperature monitor back end
package tmon_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_LOCAL     = 8'h00;
  localparam logic [7:0] ADDR_REM_UPPER = 8'h01;
  localparam logic [7:0] ADDR_STATUS    = 8'h02;
  localparam logic [7:0] ADDR_CFG_RD    = 8'h03;
  localparam logic [7:0] ADDR_RATE_RD   = 8'h04;
  localparam logic [7:0] ADDR_CFG_WR    = 8'h09;
  localparam logic [7:0] ADDR_RATE_WR   = 8'h0a;
  localparam logic [7:0] ADDR_REM_FRAC  = 8'h10;
  localparam logic [7:0] ADDR_LIM_BASE  = 8'h20;
  localparam logic [2:0] LIM_COUNT      = 3'h6;

  // Limit register indexes
  localparam int LIM_L_HI   = 0;
  localparam int LIM_L_LO   = 1;
  localparam int LIM_L_TRIP = 2;
  localparam int LIM_R_HI   = 3;
  localparam int LIM_R_LO   = 4;
  localparam int LIM_R_TRIP = 5;
  localparam logic [5:0][7:0] LIM_RST = {8'h7f, 8'h00, 8'h7f, 8'h7f, 8'h00, 8'h7f};

  // Configuration fields
  localparam int         CFG_MASK_BIT  = 7;
  localparam int         CFG_STBY_BIT  = 6;
  localparam int         CFG_PIN_BIT   = 5;
  localparam int         CFG_RANGE_BIT = 2;
  localparam logic [7:0] CFG_WR_MASK   = 8'he4;
  localparam logic [7:0] CFG_RST       = 8'h00;

  // Conversion rate field
  localparam logic [3:0] RATE_RST   = 4'h8;
  localparam logic [3:0] RATE_MAX   = 4'ha;
  localparam logic [3:0] RATE_NOAVG = 4'h8;

  // Status flag positions
  localparam int         STAT_L_HI     = 6;
  localparam int         STAT_L_LO     = 5;
  localparam int         STAT_R_HI     = 4;
  localparam int         STAT_R_LO     = 3;
  localparam int         STAT_R_OPEN   = 2;
  localparam int         STAT_R_TRIP   = 1;
  localparam int         STAT_L_TRIP   = 0;
  localparam logic [7:0] STAT_ALERT_MASK = 8'h7c;

  // Averaging and result format, values in quarter degrees
  localparam logic [4:0]         AVG_LAST     = 5'h0f;
  localparam int                 AVG_SHIFT    = 4;
  localparam logic signed [13:0] EXT_OFFSET_Q = 14'sh0100;
  localparam logic signed [13:0] EXT_MAX_Q    = 14'sh03ff;
  localparam logic signed [13:0] BIN_MAX_Q    = 14'sh01fc;
  localparam logic signed [13:0] ZERO_Q       = 14'sh0000;

  // Fastest conversion period and its cycle count
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_FAST_US  = 15500;
  localparam int CONV_FAST_CYC = CONV_FAST_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_WAIT  = 2'b00,
    ST_START = 2'b01,
    ST_MEAS  = 2'b10
  } seq_state_t;
endpackage

/* src/tmon_chan_if.sv */
// Carrier between the sequencer and one result channel
`timescale 1ns/1ps
interface tmon_chan_if;
  logic               sample_vld;
  logic               sample_last;
  logic               sample_bad;
  logic               avg_on;
  logic               range_ext;
  logic signed [11:0] raw_q;
  logic [7:0]         hi_lim;
  logic [7:0]         lo_lim;
  logic [7:0]         trip_lim;
  logic               res_vld;
  logic [7:0]         res_upper;
  logic [7:0]         res_frac;
  logic               over_hi;
  logic               under_lo;
  logic               over_trip;

  modport ctrl (output sample_vld, sample_last, sample_bad, avg_on, range_ext, raw_q,
                output hi_lim, lo_lim, trip_lim,
                input res_vld, res_upper, res_frac, over_hi, under_lo, over_trip);
  modport chan (input sample_vld, sample_last, sample_bad, avg_on, range_ext, raw_q,
                input hi_lim, lo_lim, trip_lim,
                output res_vld, res_upper, res_frac, over_hi, under_lo, over_trip);
endinterface

/* src/tmon_channel.sv */
// One channel: averaging, formatting, result storage and limit compare
`timescale 1ns/1ps
module tmon_channel (
  input wire logic  clk,
  input wire logic  sys_rst,
  tmon_chan_if.chan ch
);
  import tmon_pkg::*;

  logic signed [15:0] acc_ff;
  logic               bad_ff;
  logic [7:0]         upper_ff;
  logic [7:0]         frac_ff;
  logic               vld_ff;
  wire  signed [15:0] acc_sum;
  wire  signed [13:0] mean_q;
  wire  signed [13:0] fmt_q;
  wire  signed [13:0] max_q;
  wire  signed [13:0] clamp_q;
  wire                store;

  // Mean of sixteen samples, or the single sample when averaging is off
  assign acc_sum = acc_ff + {{4{ch.raw_q[11]}}, ch.raw_q};
  assign mean_q  = ch.avg_on ? 14'(acc_sum >>> AVG_SHIFT)
                             : {{2{ch.raw_q[11]}}, ch.raw_q};
  // Range is taken at completion, so a range change shows on the next result
  assign fmt_q   = ch.range_ext ? mean_q + EXT_OFFSET_Q : mean_q;
  assign max_q   = ch.range_ext ? EXT_MAX_Q : BIN_MAX_Q;
  assign clamp_q = (fmt_q < ZERO_Q) ? ZERO_Q : (fmt_q > max_q) ? max_q : fmt_q;
  // A faulty sample anywhere in the group keeps the last good result
  assign store   = ch.sample_vld && ch.sample_last && !(bad_ff || ch.sample_bad);

  // Accumulate and commit whole results only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_ff   <= 16'sh0000;
      bad_ff   <= 1'b0;
      upper_ff <= 8'h00;
      frac_ff  <= 8'h00;
      vld_ff   <= 1'b0;
    end else begin
      vld_ff <= store;
      if (ch.sample_vld) begin
        acc_ff <= ch.sample_last ? 16'sh0000 : acc_sum;
        bad_ff <= ch.sample_last ? 1'b0 : (bad_ff || ch.sample_bad);
      end
      if (store) begin
        upper_ff <= clamp_q[9:2];
        frac_ff  <= {clamp_q[1:0], 6'h00};
      end
    end
  end

  // High is strictly above, low is at or below
  assign ch.over_hi   = upper_ff > ch.hi_lim;
  assign ch.under_lo  = upper_ff <= ch.lo_lim;
  assign ch.over_trip = upper_ff > ch.trip_lim;
  assign ch.res_upper = upper_ff;
  assign ch.res_frac  = frac_ff;
  assign ch.res_vld   = vld_ff;

  short_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    ch.sample_vld && ch.sample_last && ch.sample_bad |=> $stable(upper_ff) && !vld_ff)
    else $error("faulty group overwrote the result");
  bin_clamp_a: assert property (@(posedge clk) disable iff (sys_rst)
    vld_ff && !$past(ch.range_ext) |-> upper_ff <= 8'h7f && frac_ff[5:0] == 6'h00)
    else $error("binary result out of range");
endmodule

/* src/tmon_backend.sv */
// Temperature monitor back end: sequencer, registers, alert and trip pins
//
// Functional notes
// - Sequencer free-runs, alternating local and remote
// - Each result compared; violations set status flags
// - High or low violation asserts alert low
// - Remote open diode also asserts alert; a shorted diode sets no flag
// - Above trip limit drives trip pin low
// - Alert pin selectable as second trip output
// - Host writes settings, reads every register
// - Settings: standby, range, mask, pin, rate
// - Slow rates average sixteen measurement cycles
// - Rates 16, 32, 64 report single measurements
// - Local result one byte at 0x00
// - Remote upper 0x01, fraction 0x10, quarter degree
// - Fraction uses top two bits, rest zero
// - Fraction read freezes upper until read
// - Config bit 2 selects extended range
// - New range valid from next cycle
// - Shorted diode keeps last valid result
// - Binary default range, offset 64 extended
// - Encodings match the published examples
// - Binary range clamps to 0 and 127
// - Range change leaves limit values untouched
// - High strictly greater, low at or below
`timescale 1ns/1ps
module tmon_backend #(
  parameter int CONV_FAST_CYCLES = tmon_pkg::CONV_FAST_CYC
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  output logic                    meas_start,
  output logic                    meas_remote,
  input  wire logic               meas_valid,
  input  wire logic signed [11:0] meas_temp_q,
  input  wire logic               meas_short,
  input  wire logic               meas_open,
  output logic                    alert_pin_o,
  output logic                    alert_pin_oe,
  output logic                    thermal_trip_out_o,
  output logic                    thermal_trip_out_oe
);
  import tmon_pkg::*;

  // Control and result state
  seq_state_t  st_ff;
  seq_state_t  nxt_st;
  logic        chan_ff;
  logic        nxt_chan;
  logic [4:0]  samp_cnt_ff;
  logic [4:0]  nxt_samp_cnt;
  logic        avg_ff;
  logic        nxt_avg;
  logic [31:0] tick_cnt_ff;
  logic [7:0]  cfg_ff;
  logic [3:0]  rate_ff;
  logic [7:0]  stat_ff;
  logic [7:0]  lim_ff [6];
  logic [7:0]  rem_upper_ff;
  logic        lock_ff;
  logic [7:0]  reg_rdata_ff;
  logic        meas_start_ff;
  logic        meas_remote_ff;
  logic        alert_pin_oe_ff;
  logic        alert_pin_o_ff;
  logic        trip_oe_ff;
  logic        trip_o_ff;

  wire [31:0] period_cyc;
  wire        standby;
  wire        tick;
  wire        samp_last;
  wire        samp_take;
  wire        wr_cfg;
  wire        wr_rate;
  wire        wr_lim;
  wire        rd_status;
  wire        rd_frac;
  wire        rd_upper;
  wire        lim_hit;
  wire [2:0]  lim_idx;
  wire [7:0]  lim_rd;
  wire [7:0]  rd_mux;
  wire [7:0]  stat_set;
  wire [7:0]  nxt_stat;
  wire        alert_src;
  wire        alert_drive;
  wire        trip_drive;

  tmon_chan_if loc_if ();
  tmon_chan_if rem_if ();

  tmon_channel u_local (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ch      (loc_if.chan)
  );

  tmon_channel u_remote (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ch      (rem_if.chan)
  );

  // Conversion period doubles for each code step below the fastest rate
  assign period_cyc = 32'(CONV_FAST_CYCLES) << (RATE_MAX - rate_ff);
  assign standby    = cfg_ff[CFG_STBY_BIT];
  assign tick       = (st_ff == ST_WAIT) && !standby
                      && (tick_cnt_ff >= period_cyc - 32'h1);
  assign samp_take  = (st_ff == ST_MEAS) && meas_valid;
  assign samp_last  = !avg_ff || (samp_cnt_ff == AVG_LAST);

  // Sequencer next state: local group, then remote group, then wait
  always_comb begin
    nxt_st       = st_ff;
    nxt_chan     = chan_ff;
    nxt_samp_cnt = samp_cnt_ff;
    nxt_avg      = avg_ff;
    unique case (st_ff)
      ST_WAIT: begin
        if (tick) begin
          nxt_st       = ST_START;
          nxt_chan     = 1'b0;
          nxt_samp_cnt = 5'h00;
          nxt_avg      = rate_ff < RATE_NOAVG;
        end
      end
      ST_START: begin
        nxt_st = ST_MEAS;
      end
      ST_MEAS: begin
        if (meas_valid) begin
          if (!samp_last) begin
            nxt_st       = ST_START;
            nxt_samp_cnt = samp_cnt_ff + 5'h01;
          end else if (!chan_ff) begin
            nxt_st       = ST_START;
            nxt_chan     = 1'b1;
            nxt_samp_cnt = 5'h00;
          end else begin
            nxt_st = ST_WAIT;
          end
        end
      end
      default: begin
        nxt_st = ST_WAIT;
      end
    endcase
  end

  // Sequencer registers; a group in flight finishes even if standby is set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff          <= ST_WAIT;
      chan_ff        <= 1'b0;
      samp_cnt_ff    <= 5'h00;
      avg_ff         <= 1'b0;
      tick_cnt_ff    <= 32'h0;
      meas_start_ff  <= 1'b0;
      meas_remote_ff <= 1'b0;
    end else begin
      st_ff          <= nxt_st;
      chan_ff        <= nxt_chan;
      samp_cnt_ff    <= nxt_samp_cnt;
      avg_ff         <= nxt_avg;
      tick_cnt_ff    <= (st_ff != ST_WAIT || standby || tick) ? 32'h0 : tick_cnt_ff + 32'h1;
      meas_start_ff  <= nxt_st == ST_START;
      meas_remote_ff <= nxt_chan;
    end
  end

  // Channel feeds; the local channel has no diode fault
  assign loc_if.sample_vld  = samp_take && !chan_ff;
  assign rem_if.sample_vld  = samp_take && chan_ff;
  assign loc_if.sample_last = samp_last;
  assign rem_if.sample_last = samp_last;
  assign loc_if.sample_bad  = 1'b0;
  assign rem_if.sample_bad  = meas_short || meas_open;
  assign loc_if.avg_on      = avg_ff;
  assign rem_if.avg_on      = avg_ff;
  assign loc_if.range_ext   = cfg_ff[CFG_RANGE_BIT];
  assign rem_if.range_ext   = cfg_ff[CFG_RANGE_BIT];
  assign loc_if.raw_q       = meas_temp_q;
  assign rem_if.raw_q       = meas_temp_q;
  assign loc_if.hi_lim      = lim_ff[LIM_L_HI];
  assign loc_if.lo_lim      = lim_ff[LIM_L_LO];
  assign loc_if.trip_lim    = lim_ff[LIM_L_TRIP];
  assign rem_if.hi_lim      = lim_ff[LIM_R_HI];
  assign rem_if.lo_lim      = lim_ff[LIM_R_LO];
  assign rem_if.trip_lim    = lim_ff[LIM_R_TRIP];

  // Register access decode
  assign wr_cfg    = reg_wr && (reg_addr == ADDR_CFG_WR);
  assign wr_rate   = reg_wr && (reg_addr == ADDR_RATE_WR) && (reg_wdata <= {4'h0, RATE_MAX});
  assign lim_idx   = reg_addr[2:0];
  assign lim_hit   = (reg_addr[7:3] == ADDR_LIM_BASE[7:3]) && (lim_idx < LIM_COUNT);
  assign wr_lim    = reg_wr && lim_hit;
  assign rd_status = reg_rd && (reg_addr == ADDR_STATUS);
  assign rd_frac   = reg_rd && (reg_addr == ADDR_REM_FRAC);
  assign rd_upper  = reg_rd && (reg_addr == ADDR_REM_UPPER);
  assign lim_rd    = lim_hit ? lim_ff[lim_idx] : 8'h00;

  // Read selection; unmapped addresses read zero
  assign rd_mux = (reg_addr == ADDR_LOCAL)     ? loc_if.res_upper :
                  (reg_addr == ADDR_REM_UPPER) ? rem_upper_ff :
                  (reg_addr == ADDR_REM_FRAC)  ? rem_if.res_frac :
                  (reg_addr == ADDR_STATUS)    ? stat_ff :
                  (reg_addr == ADDR_CFG_RD)    ? cfg_ff :
                  (reg_addr == ADDR_RATE_RD)   ? {4'h0, rate_ff} : lim_rd;

  // Settings and limits; range writes do not touch the limits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_ff  <= CFG_RST;
      rate_ff <= RATE_RST;
      for (int i = 0; i < 6; i++) begin
        lim_ff[i] <= LIM_RST[i];
      end
    end else begin
      if (wr_cfg) begin
        cfg_ff <= reg_wdata & CFG_WR_MASK;
      end
      if (wr_rate) begin
        rate_ff <= reg_wdata[3:0];
      end
      if (wr_lim) begin
        lim_ff[lim_idx] <= reg_wdata;
      end
    end
  end

  // Status flags from each completed result, the open flag from each remote sample; a set beats a clear-on-read
  assign stat_set[STAT_L_HI]   = loc_if.res_vld && loc_if.over_hi;
  assign stat_set[STAT_L_LO]   = loc_if.res_vld && loc_if.under_lo;
  assign stat_set[STAT_R_HI]   = rem_if.res_vld && rem_if.over_hi;
  assign stat_set[STAT_R_LO]   = rem_if.res_vld && rem_if.under_lo;
  assign stat_set[STAT_R_OPEN] = rem_if.sample_vld && meas_open;
  assign stat_set[STAT_R_TRIP] = rem_if.res_vld && rem_if.over_trip;
  assign stat_set[STAT_L_TRIP] = loc_if.res_vld && loc_if.over_trip;
  assign stat_set[7]           = 1'b0;
  assign nxt_stat = (rd_status ? 8'h00 : stat_ff) | stat_set;

  // Pin drive: trip compares are live so limit writes in standby act at once
  assign alert_src   = |(stat_ff & STAT_ALERT_MASK);
  assign alert_drive = cfg_ff[CFG_PIN_BIT] ? (loc_if.over_hi || rem_if.over_hi)
                                           : (alert_src && !cfg_ff[CFG_MASK_BIT]);
  assign trip_drive  = loc_if.over_trip || rem_if.over_trip;

  // Status, tear guard, read data and pin registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_ff         <= 8'h00;
      rem_upper_ff    <= 8'h00;
      lock_ff         <= 1'b0;
      reg_rdata_ff    <= 8'h00;
      alert_pin_oe_ff <= 1'b0;
      alert_pin_o_ff  <= 1'b0;
      trip_oe_ff      <= 1'b0;
      trip_o_ff       <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      if (!lock_ff) begin
        rem_upper_ff <= rem_if.res_upper;
      end
      if (rd_frac) begin
        lock_ff <= 1'b1;
      end else if (rd_upper) begin
        lock_ff <= 1'b0;
      end
      if (reg_rd) begin
        reg_rdata_ff <= rd_mux;
      end
      alert_pin_oe_ff <= alert_drive;
      alert_pin_o_ff  <= 1'b0;
      trip_oe_ff      <= trip_drive;
      trip_o_ff       <= 1'b0;
    end
  end

  assign reg_rdata           = reg_rdata_ff;
  assign meas_start          = meas_start_ff;
  assign meas_remote         = meas_remote_ff;
  assign alert_pin_o         = alert_pin_o_ff;
  assign alert_pin_oe        = alert_pin_oe_ff;
  assign thermal_trip_out_o  = trip_o_ff;
  assign thermal_trip_out_oe = trip_oe_ff;

  // Checks
  seq_alternate_a: assert property (@(posedge clk) disable iff (sys_rst)
    samp_take && samp_last && !chan_ff |=> meas_start_ff && meas_remote_ff)
    else $error("remote group did not follow local group");
  standby_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_ff == ST_WAIT && standby |=> st_ff == ST_WAIT && !meas_start_ff)
    else $error("conversion started in standby");
  status_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    rem_if.res_vld && rem_if.over_hi |=> stat_ff[STAT_R_HI])
    else $error("remote high flag not set");
  alert_assert_a: assert property (@(posedge clk) disable iff (sys_rst)
    |(stat_ff & STAT_ALERT_MASK) && !cfg_ff[CFG_MASK_BIT] && !cfg_ff[CFG_PIN_BIT]
    |=> alert_pin_oe_ff)
    else $error("alert not driven for set flag");
  open_alert_a: assert property (@(posedge clk) disable iff (sys_rst)
    rem_if.sample_vld && meas_open && cfg_ff == CFG_RST && !wr_cfg
    |=> ##1 alert_pin_oe_ff)
    else $error("diode fault did not raise alert");
  trip_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    (loc_if.over_trip || rem_if.over_trip) |=> thermal_trip_out_oe && !thermal_trip_out_o)
    else $error("trip pin not driven low");
  second_trip_a: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_ff[CFG_PIN_BIT] && cfg_ff[CFG_MASK_BIT] && rem_if.over_hi |=> alert_pin_oe_ff)
    else $error("second trip ignored or masked");
  avg_group_a: assert property (@(posedge clk) disable iff (sys_rst)
    samp_take && avg_ff && samp_cnt_ff != AVG_LAST |=> !loc_if.res_vld && !rem_if.res_vld)
    else $error("result stored mid average");
  single_sample_a: assert property (@(posedge clk) disable iff (sys_rst)
    samp_take && !avg_ff && !chan_ff |=> loc_if.res_vld)
    else $error("single measurement not reported");
  upper_lock_a: assert property (@(posedge clk) disable iff (sys_rst)
    rd_frac |=> lock_ff ##1 (lock_ff || $past(rd_upper)) && $stable(rem_upper_ff))
    else $error("upper byte changed while locked");
  // The remote high and local low limits move only on limit writes, whatever the range setting does
  limit_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    !wr_lim |=> $stable(lim_ff[LIM_R_HI]) && $stable(lim_ff[LIM_L_LO]))
    else $error("limit changed without a limit write");
  // A period tick always opens with a local measurement
  run_tick_a: assert property (@(posedge clk) disable iff (sys_rst)
    tick |=> meas_start_ff && !meas_remote_ff)
    else $error("period did not start a local measurement");
  // Reserved rate codes leave the running rate alone
  rate_refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == ADDR_RATE_WR && reg_wdata > {4'h0, RATE_MAX} |=> $stable(rate_ff))
    else $error("reserved rate code accepted");
  alert_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    !cfg_ff[CFG_PIN_BIT] && cfg_ff[CFG_MASK_BIT] |=> !alert_pin_oe_ff)
    else $error("masked alert still driven");
  // A status read with no new event leaves every flag clear
  status_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    rd_status && stat_set == 8'h00 |=> stat_ff == 8'h00)
    else $error("status flags survived a read");
  // The upper byte read returns the value frozen by the fraction read
  upper_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    rd_upper |=> reg_rdata_ff == $past(rem_upper_ff))
    else $error("upper byte read returned a torn value");
endmodule

/* sim/tmon_adc_model.sv */
// Behavioural converter that answers each measurement start
`timescale 1ns/1ps
module tmon_adc_model #(
  parameter int DLY = 3
) (
  input  wire logic               clk,
  input  wire logic               meas_start,
  input  wire logic               meas_remote,
  input  wire logic signed [11:0] loc_q,
  input  wire logic signed [11:0] rem_q,
  input  wire logic               short_en,
  input  wire logic               open_en,
  input  wire logic               dither,
  output logic                    meas_valid = 1'b0,
  output logic signed [11:0]      meas_temp_q = 12'sh000,
  output logic                    meas_short = 1'b0,
  output logic                    meas_open = 1'b0
);
  int   cnt = 0;
  logic odd = 1'b0;

  // Data wanders between answers so a stale sample never looks valid
  always @(negedge clk) begin
    meas_valid <= (cnt == 1);
    meas_short <= (cnt == 1) && meas_remote && short_en;
    meas_open  <= (cnt == 1) && meas_remote && open_en;
    if (cnt == 1) begin
      meas_temp_q <= (meas_remote ? rem_q : loc_q) + ((dither && odd) ? 12'sd4 : 12'sd0);
      odd         <= !odd;
    end else begin
      meas_temp_q <= ~meas_temp_q;
    end
    if (meas_start) begin
      cnt <= DLY;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

/* sim/temp_result_format_compare_tb_top.sv */
// Self-checking bench for the temperature monitor back end
`timescale 1ns/1ps
module temp_result_format_compare_tb_top;
  import tmon_pkg::*;
  logic               clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic [7:0]         reg_addr = 8'h00;
  logic [7:0]         reg_wdata = 8'h00;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [7:0]         reg_rdata;
  logic               meas_start;
  logic               meas_remote;
  logic               meas_valid;
  logic               meas_short;
  logic               meas_open;
  logic signed [11:0] meas_temp_q;
  logic               alert_pin_o;
  logic               alert_pin_oe;
  logic               thermal_trip_out_o;
  logic               thermal_trip_out_oe;
  logic signed [11:0] loc_q = 12'sh064;
  logic signed [11:0] rem_q = 12'sh067;
  logic               short_en = 1'b0;
  logic               open_en = 1'b0;
  logic               dither = 1'b0;
  int                 fails = 0;
  int                 compares = 0;

  tmon_backend #(.CONV_FAST_CYCLES(20)) tmon_backend_i (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .meas_start(meas_start), .meas_remote(meas_remote),
    .meas_valid(meas_valid), .meas_temp_q(meas_temp_q), .meas_short(meas_short),
    .meas_open(meas_open), .alert_pin_o(alert_pin_o), .alert_pin_oe(alert_pin_oe),
    .thermal_trip_out_o(thermal_trip_out_o), .thermal_trip_out_oe(thermal_trip_out_oe));
  tmon_adc_model tmon_adc_model_i (.clk(clk), .meas_start(meas_start),
    .meas_remote(meas_remote), .loc_q(loc_q), .rem_q(rem_q), .short_en(short_en),
    .open_en(open_en), .dither(dither), .meas_valid(meas_valid),
    .meas_temp_q(meas_temp_q), .meas_short(meas_short), .meas_open(meas_open));

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic end_sim;
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Strobes are one-cycle pulses launched at the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask

  // Count remote answers; three spare cycles let flags reach the pins
  task automatic wait_rem(input int n);
    int t;
    t = 0;
    while (n > 0) begin
      @(posedge clk);
      if (meas_valid && meas_remote) n--;
      t++;
      if (t > 20000) begin
        fails++;
        end_sim();
      end
    end
    repeat (3) @(negedge clk);
  endtask

  initial begin
    int n;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    rd(ADDR_REM_UPPER, 8'h00);
    rd(ADDR_CFG_RD, CFG_RST);
    wr(ADDR_RATE_WR, 8'h0b);
    rd(ADDR_RATE_RD, 8'h08);
    rd(8'h05, 8'h00);
    wait_rem(2);
    rd(ADDR_LOCAL, 8'h19);
    rd(ADDR_REM_FRAC, 8'hc0);
    rem_q = 12'sh1f4;
    wait_rem(2);
    rd(ADDR_REM_UPPER, 8'h19);
    rd(ADDR_REM_UPPER, 8'h7d);
    // Out of the binary span in both directions
    loc_q = 12'sh258;
    rem_q = -12'sd40;
    wait_rem(2);
    rd(ADDR_LOCAL, 8'h7f);
    rd(ADDR_REM_FRAC, 8'h00);
    rd(ADDR_REM_UPPER, 8'h00);
    chk(8'(alert_pin_oe), 8'h01);
    chk(8'(thermal_trip_out_oe), 8'h00);
    // Offset format, limits left as they were; the remote value moves only after
    // the range has, so no stray binary low flag lands after the status read
    loc_q = 12'sh064;
    wr(ADDR_CFG_WR, 8'h04);
    rd(ADDR_STATUS, 8'h08);
    rem_q = 12'sh1f4;
    wait_rem(2);
    rd(ADDR_LOCAL, 8'h59);
    rd(ADDR_REM_UPPER, 8'hbd);
    rd(ADDR_LIM_BASE + 8'h03, 8'h7f);
    chk(8'(thermal_trip_out_oe), 8'h01);
    rd(ADDR_STATUS, 8'h12);
    wait_rem(1);
    rd(ADDR_STATUS, 8'h12);
    chk(8'(alert_pin_o | thermal_trip_out_o), 8'h00);
    // Second-trip mode ignores the mask; standby stops conversions
    wr(ADDR_CFG_WR, 8'hff);
    rd(ADDR_CFG_RD, 8'he4);
    chk(8'(alert_pin_oe), 8'h01);
    repeat (200) @(posedge clk);
    n = 0;
    repeat (300) begin
      @(negedge clk);
      n += meas_start;
    end
    chk(n[7:0], 8'h00);
    wr(ADDR_CFG_WR, 8'h84);
    repeat (3) @(negedge clk);
    chk(8'(alert_pin_oe), 8'h00);
    // Shorted diode keeps the old result; open diode raises the alert
    wr(ADDR_CFG_WR, 8'h00);
    rem_q = 12'sh064;
    wait_rem(2);
    short_en = 1'b1;
    rem_q = 12'sh0c8;
    wait_rem(2);
    rd(ADDR_REM_FRAC, 8'h00);
    rd(ADDR_REM_UPPER, 8'h19);
    short_en = 1'b0;
    open_en = 1'b1;
    rd(ADDR_STATUS, 8'h00);
    wait_rem(1);
    chk(8'(alert_pin_oe), 8'h01);
    rd(ADDR_STATUS, 8'h04);
    // Dithered samples show their mean only when averaging
    open_en = 1'b0;
    dither = 1'b1;
    rem_q = 12'sh064;
    for (int r = 7; r <= 10; r++) begin
      wr(ADDR_RATE_WR, 8'(r));
      wait_rem(34);
      rd(ADDR_REM_FRAC, (r < 8) ? 8'h80 : 8'h00);
    end
    end_sim();
  end
endmodule
